/* design/ccs_params.svh */
/*
  Constants of the completion stream source: register offsets, field
  positions, reset values and stream geometry.
  Assumes inclusion by its bare name from every file that needs it.
*/
`ifndef CCS_PARAMS_SVH
`define CCS_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------------
`define CCS_OFF_CTRL       8'h00
`define CCS_OFF_LEN        8'h04
`define CCS_OFF_SEED       8'h08
`define CCS_OFF_ABORT      8'h0C
`define CCS_OFF_STATUS     8'h10
`define CCS_OFF_COUNT      8'h14

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CCS_CTRL_START     0
`define CCS_CTRL_STRADDLE  1
`define CCS_CTRL_PARITY    2
`define CCS_CTRL_ABORT     3
`define CCS_STAT_BUSY      0
`define CCS_STAT_ABORTED   1

// ----------------------------------------------------------------------
// reset values and stream geometry
// ----------------------------------------------------------------------
`define CCS_RST_LEN        11'h010
`define CCS_RST_SEED       32'h0000_0000
`define CCS_RST_ABORT      7'h00
`define CCS_DW_PER_BEAT    16
`define CCS_FLAGS_ONE      2'b01
`define CCS_LANE_ZERO      2'b00

`endif

/* design/ccs_parity_gen.sv */
/*
  Odd parity per byte of a data word.
  Assumes the caller registers the result.
*/
`timescale 1ns/1ns
`default_nettype none
module ccs_parity_gen #(
  parameter int BYTES = 64
) (
  input  wire logic [BYTES*8-1:0] data,
  output logic      [BYTES-1:0]   par
);

  genvar i;
  generate
    for (i = 0; i < BYTES; i++) begin : g_byte
      // byte plus its bit carries an odd number of ones
      assign par[i] = ~^data[i*8 +: 8];
    end
  endgenerate

endmodule
`default_nettype wire

/* design/ccs_pkg.sv */
/*
  Types of the completion stream source: sideband layout, mode bits and
  controller states.
  Assumes a tool that reads packed structs MSB first.
*/
package ccs_pkg;

  // ----------------------------------------------------------------------
  // sideband layout, 183 bits, bit 0 last in the list
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [101:0] rsvd;
    logic [63:0]  parity;
    logic         discontinue;
    logic [3:0]   second_end_dword_offset;
    logic [3:0]   first_end_dword_offset;
    logic [1:0]   tlp_end_flags;
    logic [1:0]   second_start_lane;
    logic [1:0]   first_start_lane;
    logic [1:0]   tlp_start_flags;
  } ccs_sideband_t;

  typedef struct packed {
    logic straddle;
    logic parity_en;
    logic abort_en;
  } ccs_mode_t;

  typedef enum logic [1:0] {
    CCS_IDLE = 2'b01,
    CCS_SEND = 2'b10
  } ccs_state_t;

endpackage

/* design/ccs_source.sv */
/*
  Completion stream source: frames one completion packet of an
  incrementing dword pattern into 512-bit beats for the core's completer
  completion input, on command from software over AHB-Lite.
  Assumes one AHB-Lite master, whole-word transfers, and that the core's
  ready input is synchronous to hclk.
*/
// The AHB-Lite slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ccs_params.svh"
module ccs_source #(
  parameter int LEN_W  = 11,
  parameter int BEAT_W = 7
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic [31:0]                hrdata,
  output logic [511:0]               cpl_in_data,
  output ccs_pkg::ccs_sideband_t     cpl_in_sideband,
  output logic                       cpl_in_end_marker,
  output logic [15:0]                cpl_in_dword_mask,
  output logic                       cpl_in_valid,
  input  wire logic [3:0]            cpl_in_ready
);
  import ccs_pkg::*;

  // ----------------------------------------------------------------------
  // bus slave state
  // ----------------------------------------------------------------------
  logic              wr_pend_ff;
  logic              nxt_wr_pend;
  logic [7:0]        wr_addr_ff;
  logic [7:0]        nxt_wr_addr;
  logic [31:0]       hrdata_ff;
  logic [31:0]       nxt_hrdata;
  logic              addr_phase;

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------
  ccs_mode_t         mode_ff;
  ccs_mode_t         nxt_mode;
  logic [LEN_W-1:0]  len_ff;
  logic [LEN_W-1:0]  nxt_len;
  logic [31:0]       seed_ff;
  logic [31:0]       nxt_seed;
  logic [BEAT_W-1:0] abort_beat_ff;
  logic [BEAT_W-1:0] nxt_abort_beat;
  logic [15:0]       pkt_cnt_ff;
  logic [15:0]       nxt_pkt_cnt;
  logic [15:0]       abort_cnt_ff;
  logic [15:0]       nxt_abort_cnt;
  logic              aborted_ff;
  logic              nxt_aborted;

  // ----------------------------------------------------------------------
  // stream state
  // ----------------------------------------------------------------------
  ccs_state_t        state_ff;
  ccs_state_t        nxt_state;
  logic [BEAT_W-1:0] beat_ff;
  logic [BEAT_W-1:0] nxt_beat;
  logic [511:0]      data_ff;
  logic [511:0]      nxt_data;
  ccs_sideband_t     sb_ff;
  ccs_sideband_t     nxt_sb;
  logic              last_ff;
  logic              nxt_last;
  logic [15:0]       keep_ff;
  logic [15:0]       nxt_keep;
  logic              valid_ff;
  logic              nxt_valid;

  logic              wr_en;
  ccs_mode_t         pkt_mode;
  logic              start_req;
  logic              handshake;
  logic              load;
  logic [BEAT_W-1:0] load_beat;
  logic [LEN_W:0]    len_plus;
  logic [BEAT_W-1:0] last_beat;
  logic              abort_hit;
  logic [BEAT_W-1:0] eff_last;
  logic [3:0]        rem;
  logic [15:0]       rem_mask;
  logic [511:0]      gen_data;
  logic [63:0]       gen_par;

  // ----------------------------------------------------------------------
  // packet geometry
  // ----------------------------------------------------------------------
  // beats = ceil(len/16); the last index also bounds the abort beat
  assign len_plus  = {1'b0, len_ff} + (LEN_W+1)'(`CCS_DW_PER_BEAT - 1);
  assign last_beat = BEAT_W'((len_plus >> 4) - (LEN_W+1)'(1));
  assign rem       = len_ff[3:0];
  assign rem_mask  = (rem == 4'h0) ? 16'hFFFF : 16'((17'h1 << rem) - 17'h1);
  // mode bits of a START write govern the very first beat, which is
  // loaded in the same cycle as that write lands in mode_ff
  assign pkt_mode  = start_req ? ccs_mode_t'({hwdata[`CCS_CTRL_STRADDLE],
                                              hwdata[`CCS_CTRL_PARITY],
                                              hwdata[`CCS_CTRL_ABORT]})
                               : mode_ff;
  // abort never lands on beat 0, and only inside the packet
  assign abort_hit = pkt_mode.abort_en && (abort_beat_ff != '0)
                     && (abort_beat_ff <= last_beat);
  assign eff_last  = abort_hit ? abort_beat_ff : last_beat;

  // the beat is taken on bit 0 alone; all four bits carry one value
  assign handshake = valid_ff && cpl_in_ready[0];
  assign load      = start_req || (handshake && (beat_ff != eff_last));
  assign load_beat = start_req ? '0 : BEAT_W'(beat_ff + BEAT_W'(1));

  genvar i;
  generate
    for (i = 0; i < `CCS_DW_PER_BEAT; i++) begin : g_dw
      assign gen_data[i*32 +: 32] = seed_ff + 32'({load_beat, 4'(i)});
    end
  endgenerate

  ccs_parity_gen #(
    .BYTES (64)
  ) u_par (
    .data (gen_data),
    .par  (gen_par)
  );

  // ----------------------------------------------------------------------
  // stream framing
  // ----------------------------------------------------------------------
  always_comb begin
    nxt_state     = state_ff;
    nxt_beat      = beat_ff;
    nxt_data      = data_ff;
    nxt_sb        = sb_ff;
    nxt_last      = last_ff;
    nxt_keep      = keep_ff;
    nxt_valid     = valid_ff;
    nxt_pkt_cnt   = pkt_cnt_ff;
    nxt_abort_cnt = abort_cnt_ff;
    nxt_aborted   = aborted_ff;
    unique case (state_ff)
      CCS_IDLE: begin
        if (start_req) begin
          nxt_state   = CCS_SEND;
          nxt_valid   = 1'b1;
          nxt_aborted = 1'b0;
        end
      end
      CCS_SEND: begin
        if (handshake && (beat_ff == eff_last)) begin
          nxt_state   = CCS_IDLE;
          nxt_valid   = 1'b0;
          // a stale abort bit must not stand once valid has dropped
          nxt_sb.discontinue = 1'b0;
          nxt_pkt_cnt = pkt_cnt_ff + 16'h0001;
          if (sb_ff.discontinue) begin
            nxt_abort_cnt = abort_cnt_ff + 16'h0001;
            nxt_aborted   = 1'b1;
          end
        end
      end
    endcase
    // outputs change only on a new beat or when valid drops at the end, so a stalled beat stays put
    if (load) begin
      nxt_beat = load_beat;
      nxt_data = gen_data;
      nxt_sb   = '0;
      // packets always start at lane 0, one per beat, so a second start
      // and a start beside an aborted end never occur
      nxt_sb.tlp_start_flags  = (load_beat == '0) ? `CCS_FLAGS_ONE : 2'b00;
      nxt_sb.first_start_lane = `CCS_LANE_ZERO;
      nxt_last = (load_beat == eff_last);
      nxt_keep = (load_beat == last_beat) ? rem_mask : 16'hFFFF;
      if (pkt_mode.straddle && (load_beat == eff_last)) begin
        nxt_sb.tlp_end_flags = `CCS_FLAGS_ONE;
        nxt_sb.first_end_dword_offset =
          (load_beat == last_beat) ? 4'(rem - 4'h1) : 4'hF;
      end
      // early end in the abort beat; raised only with valid high
      nxt_sb.discontinue = abort_hit && (load_beat == abort_beat_ff);
      nxt_sb.parity = pkt_mode.parity_en ? gen_par : 64'h0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_ff     <= CCS_IDLE;
      beat_ff      <= '0;
      data_ff      <= '0;
      sb_ff        <= '0;
      last_ff      <= 1'b0;
      keep_ff      <= 16'h0000;
      valid_ff     <= 1'b0;
      pkt_cnt_ff   <= 16'h0000;
      abort_cnt_ff <= 16'h0000;
      aborted_ff   <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      beat_ff      <= nxt_beat;
      data_ff      <= nxt_data;
      sb_ff        <= nxt_sb;
      last_ff      <= nxt_last;
      keep_ff      <= nxt_keep;
      valid_ff     <= nxt_valid;
      pkt_cnt_ff   <= nxt_pkt_cnt;
      abort_cnt_ff <= nxt_abort_cnt;
      aborted_ff   <= nxt_aborted;
    end
  end

  // ----------------------------------------------------------------------
  // bus slave and registers
  // ----------------------------------------------------------------------
  assign addr_phase = hsel && hready && htrans[1];
  assign wr_en      = wr_pend_ff && (state_ff == CCS_IDLE);
  assign start_req  = wr_en && (wr_addr_ff == `CCS_OFF_CTRL)
                      && hwdata[`CCS_CTRL_START] && (len_ff != '0);

  always_comb begin
    nxt_wr_pend    = addr_phase && hwrite && (hsize == 3'h2);
    nxt_wr_addr    = addr_phase ? haddr[7:0] : wr_addr_ff;
    nxt_mode       = mode_ff;
    nxt_len        = len_ff;
    nxt_seed       = seed_ff;
    nxt_abort_beat = abort_beat_ff;
    // settings are frozen while a packet is on the stream
    if (wr_en) begin
      unique case (wr_addr_ff)
        `CCS_OFF_CTRL: begin
          nxt_mode.straddle  = hwdata[`CCS_CTRL_STRADDLE];
          nxt_mode.parity_en = hwdata[`CCS_CTRL_PARITY];
          nxt_mode.abort_en  = hwdata[`CCS_CTRL_ABORT];
        end
        `CCS_OFF_LEN:   nxt_len        = hwdata[LEN_W-1:0];
        `CCS_OFF_SEED:  nxt_seed       = hwdata;
        `CCS_OFF_ABORT: nxt_abort_beat = hwdata[BEAT_W-1:0];
        default: ;
      endcase
    end
    nxt_hrdata = hrdata_ff;
    // read values taken from next state so a write just before is seen
    if (addr_phase && !hwrite) begin
      unique case (haddr[7:0])
        `CCS_OFF_CTRL:   nxt_hrdata = {28'h0, nxt_mode.abort_en, nxt_mode.parity_en,
                                       nxt_mode.straddle, 1'b0};
        `CCS_OFF_LEN:    nxt_hrdata = 32'(nxt_len);
        `CCS_OFF_SEED:   nxt_hrdata = nxt_seed;
        `CCS_OFF_ABORT:  nxt_hrdata = 32'(nxt_abort_beat);
        `CCS_OFF_STATUS: nxt_hrdata = {30'h0, nxt_aborted, nxt_state == CCS_SEND};
        `CCS_OFF_COUNT:  nxt_hrdata = {nxt_abort_cnt, nxt_pkt_cnt};
        default:         nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff    <= 1'b0;
      wr_addr_ff    <= 8'h00;
      hrdata_ff     <= 32'h0000_0000;
      mode_ff       <= '0;
      len_ff        <= `CCS_RST_LEN;
      seed_ff       <= `CCS_RST_SEED;
      abort_beat_ff <= `CCS_RST_ABORT;
    end else begin
      wr_pend_ff    <= nxt_wr_pend;
      wr_addr_ff    <= nxt_wr_addr;
      hrdata_ff     <= nxt_hrdata;
      mode_ff       <= nxt_mode;
      len_ff        <= nxt_len;
      seed_ff       <= nxt_seed;
      abort_beat_ff <= nxt_abort_beat;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  // zero wait states: every transfer completes in a single data phase
  assign hreadyout         = 1'b1;
  assign hresp             = 1'b0;
  assign hrdata            = hrdata_ff;
  assign cpl_in_data       = data_ff;
  assign cpl_in_sideband   = sb_ff;
  assign cpl_in_end_marker = last_ff;
  assign cpl_in_dword_mask = keep_ff;
  assign cpl_in_valid      = valid_ff;

endmodule
`default_nettype wire

/* testbench/ccs_core_model.sv */
/* Receiving core model: paces beats, frames packets, counts results.
   Assumes the bench seeds the random generator and sets the modes. */
`timescale 1ns/1ns
`default_nettype none
module ccs_core_model (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   straddle,
  input  wire logic                   par_chk,
  input  wire logic                   stall,
  input  wire logic [511:0]           data,
  input  wire ccs_pkg::ccs_sideband_t sb,
  input  wire logic                   last,
  input  wire logic [15:0]            mask,
  input  wire logic                   valid,
  output logic [3:0]                  ready,
  output int                          pkts,
  output int                          nulls,
  output int                          errs,
  output int                          len,
  output logic [31:0]                 fdw,
  output logic [31:0]                 ldw
);
  import ccs_pkg::*;
  // ----
  // framing
  // ----
  logic r, inp, dis, e;
  int   n, o;
  assign ready = {4{r}};
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= 1'b0;
      {inp, dis, n, pkts, nulls, errs, len} = '0;
    end else begin
      r <= stall ? 1'($urandom) : 1'b1;
      if (valid && r) begin
        if (!inp) fdw = data[31:0];
        if (sb.tlp_start_flags[0] == inp) errs++;
        dis = dis | sb.discontinue;
        for (int i = 0; i < 64; i++)
          if (par_chk && sb.parity[i] == ^data[i*8+:8]) dis = 1'b1;
        e = straddle ? sb.tlp_end_flags[0] : last;
        o = straddle ? int'(sb.first_end_dword_offset) : $countones(mask) - 1;
        n = n + (e ? o + 1 : 16);
        inp = !e;
        if (e) begin
          ldw = data[o*32+:32];
          len = n;
          n = 0;
          if (dis) nulls++;
          else pkts++;
          dis = 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

/* testbench/ccs_source_chk.sv */
/* Assertions on the completion stream outputs of ccs_source.
   Assumes it is bound to ccs_source and sees only its ports. */
`timescale 1ns/1ns
`default_nettype none
module ccs_source_chk (
  input wire logic                   hclk,
  input wire logic                   hresetn,
  input wire logic [511:0]           cpl_in_data,
  input wire ccs_pkg::ccs_sideband_t cpl_in_sideband,
  input wire logic                   cpl_in_end_marker,
  input wire logic [15:0]            cpl_in_dword_mask,
  input wire logic                   cpl_in_valid,
  input wire logic [3:0]             cpl_in_ready
);
  import ccs_pkg::*;
  // ----
  // packet tracking
  // ----
  ccs_sideband_t s;
  logic          in_pkt_ff;
  logic          nxt_in_pkt;
  logic [63:0]   par_odd;
  logic          go;
  assign s = cpl_in_sideband;
  assign go = cpl_in_valid && cpl_in_ready[0];
  always_comb begin
    nxt_in_pkt = in_pkt_ff;
    if (go) nxt_in_pkt = !cpl_in_end_marker;
    for (int i = 0; i < 64; i++) par_odd[i] = ~^cpl_in_data[i*8+:8];
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) in_pkt_ff <= 1'b0;
    else in_pkt_ff <= nxt_in_pkt;
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  hold_stall_a: assert property (cpl_in_valid && !cpl_in_ready[0] |=> cpl_in_valid
    && $stable(cpl_in_data) && $stable(s) && $stable(cpl_in_dword_mask)
    && $stable(cpl_in_end_marker)) else $error("beat changed while stalled");
  valid_held_a: assert property (go && !cpl_in_end_marker |=> cpl_in_valid)
    else $error("valid dropped inside a packet");
  first_beat_a: assert property (cpl_in_valid && !in_pkt_ff |->
    s.tlp_start_flags == 2'b01 && s.first_start_lane == 2'b00 && !s.discontinue)
    else $error("bad first beat fields");
  mid_beat_a: assert property (cpl_in_valid && in_pkt_ff |-> s.tlp_start_flags == 2'b00)
    else $error("start flag inside a packet");
  second_tlp_a: assert property (cpl_in_valid |-> s.second_start_lane == 2'b00
    && !s.tlp_end_flags[1]) else $error("second packet fields used");
  end_flag_a: assert property (cpl_in_valid && s.tlp_end_flags[0] |-> cpl_in_end_marker)
    else $error("end flag without end marker");
  end_off_a: assert property (cpl_in_valid && s.tlp_end_flags[0] |->
    int'(s.first_end_dword_offset) == $countones(cpl_in_dword_mask) - 1)
    else $error("end offset disagrees with mask");
  dword_mask_a: assert property (cpl_in_valid |-> (cpl_in_end_marker ?
    cpl_in_dword_mask != 16'h0 && (cpl_in_dword_mask & (cpl_in_dword_mask + 16'h1)) == 16'h0
    : cpl_in_dword_mask == 16'hFFFF)) else $error("dword mask not contiguous");
  abort_valid_a: assert property (s.discontinue |-> cpl_in_valid)
    else $error("abort without valid");
  abort_end_a: assert property (cpl_in_valid && s.discontinue |-> cpl_in_end_marker)
    else $error("aborted beat does not end packet");
  parity_ok_a: assert property (cpl_in_valid |-> s.parity == 64'h0 || s.parity == par_odd)
    else $error("byte parity wrong");
  cover property (go && cpl_in_end_marker && in_pkt_ff);
  cover property (go && s.discontinue);
  cover property (cpl_in_valid && !cpl_in_ready[0]);
endmodule
bind ccs_source ccs_source_chk u_chk (.hclk, .hresetn, .cpl_in_data, .cpl_in_sideband,
  .cpl_in_end_marker, .cpl_in_dword_mask, .cpl_in_valid, .cpl_in_ready);
`default_nettype wire

/* testbench/ccs_source_tb.sv */
/* Self-checking bench of ccs_source over AHB-Lite and the core model.
   Assumes the checker and core model are compiled first. */
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin fails++; \
  $display("mismatch %s exp %0h seen %0h", n, e, s); end end
module ccs_source_tb;
  import ccs_pkg::*;
  logic          hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0]    htrans;
  logic [2:0]    hsize;
  logic [31:0]   haddr, hwdata, hrdata, r, fdw, ldw;
  logic [511:0]  data;
  ccs_sideband_t sb;
  logic [15:0]   mask;
  logic [3:0]    ready;
  logic          last, valid, strad, par, stall;
  int            fails, checks, pk_e, nu_e, pkts, nulls, errs, len;
  assign hready = hreadyout;
  ccs_source uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready, .hreadyout, .hresp, .hrdata, .cpl_in_data(data), .cpl_in_sideband(sb),
    .cpl_in_end_marker(last), .cpl_in_dword_mask(mask), .cpl_in_valid(valid),
    .cpl_in_ready(ready));
  ccs_core_model far (.clk(hclk), .rst_n(hresetn), .straddle(strad), .par_chk(par),
    .stall, .data, .sb, .last, .mask, .valid, .ready, .pkts, .nulls, .errs, .len,
    .fdw, .ldw);
  initial begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  // ----
  // bus cycle and packet tasks
  // ----
  task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsize <= 3'h2;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    r = hrdata;
  endtask
  // an abort in the natural last beat ends the packet at its full length
  task automatic run(input int n, input logic [2:0] md, input int ab);
    logic [31:0] s;
    int          k;
    int          le;
    logic        abt;
    s = $urandom;
    strad <= md[0];
    par <= md[1];
    stall <= 1'($urandom);
    ax(1'b1, 8'h04, 32'(n));
    ax(1'b1, 8'h08, s);
    ax(1'b1, 8'h0C, 32'(ab));
    ax(1'b1, 8'h00, {28'h0, md, 1'b1});
    k = 0;
    do begin
      ax(1'b0, 8'h10, 32'h0);
      k++;
    end while (r[0] && k < 400);
    abt = md[2] && ab >= 1 && ab <= (n - 1) / 16;
    le = (abt && (ab + 1) * 16 < n) ? (ab + 1) * 16 : n;
    if (abt) nu_e++;
    else pk_e++;
    `CHK("busy", 1'b0, r[0])
    `CHK("aborted", abt, r[1])
    `CHK("pkts", pk_e, pkts)
    `CHK("nulls", nu_e, nulls)
    `CHK("frame", 0, errs)
    `CHK("len", le, len)
    `CHK("first", s, fdw)
    `CHK("last", s + 32'(le) - 32'h1, ldw)
    ax(1'b0, 8'h14, 32'h0);
    `CHK("abort count", nu_e, r[31:16])
    `CHK("packet count", pk_e + nu_e, r[15:0])
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    {hresetn, strad, par, stall, fails, checks, pk_e, nu_e} = '0;
    void'($urandom(32'hADD0));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int k = 0; k < 7; k++) begin
      ax(1'b0, 8'(k * 4), 32'h0);
      `CHK("reset value", k == 1 ? 32'h10 : 32'h0, r)
      `CHK("okay response", 1'b0, hresp)
    end
    run(1, 3'b000, 0);
    run(16, 3'b001, 0);
    run(17, 3'b010, 0);
    run(20, 3'b100, 5);
    run(40, 3'b100, 1);
    run(40, 3'b111, 2);
    repeat (8) run($urandom_range(64, 1), 3'($urandom_range(3, 0)), 0);
    print_verdict;
  end
  initial begin
    #1000000;
    fails++;
    print_verdict;
  end
endmodule
`default_nettype wire
